// >>> cafc_filter_ctrl.v
// Control register and message steering for acceptance filters 24 and 25
// Operation
// [R01] Filter 25 enable at bit 15; one turns it on, zero off.
// [R02] Filter 24 enable at bit 7; one active, zero inactive.
// [R03] Filter 25 mask pick in bits 14:13; 11 mask 3, 10 mask 2.
// [R04] Filter 24 mask pick in bits 6:5; 00 selects mask 0.
// [R05] Filter 25 FIFO destination in bits 12:8, FIFO 0 to 31.
// [R06] Filter 24 FIFO destination in bits 4:0, FIFO 0 to 31.
// [R07] Mask pick and destination change only while that filter is off.
// [R08] Mask pick code 01 selects acceptance mask 1.
// [R09] Disabled filters take no part in matching or FIFO steering.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "cafc_map.vh"

module cafc_filter_ctrl #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    rst_in,
  // Register port
  input  wire [`CAFC_ADDR_W-1:0] reg_addr_in,
  input  wire [31:0]             reg_wdata_in,
  input  wire                    reg_wr_in,
  input  wire                    reg_rd_in,
  output wire [31:0]             reg_rdata_out,
  // Match pulses from the identifier compare engine, bit 0 filter 24
  input  wire [1:0]              match_in,
  // Filter settings towards the compare engine
  output wire                    filter24_on_out,
  output wire                    filter25_on_out,
  output wire [1:0]              filter24_mask_pick_out,
  output wire [1:0]              filter25_mask_pick_out,
  output wire [3:0]              filter24_mask_onehot_out,
  output wire [3:0]              filter25_mask_onehot_out,
  output wire [4:0]              filter24_fifo_dest_out,
  output wire [4:0]              filter25_fifo_dest_out,
  // Steering result towards the receive FIFOs
  output wire                    route_valid_out,
  output wire [4:0]              route_fifo_out,
  output wire                    route_filter_out
);

  localparam NFLT = 2;

  // Mask code to one-hot mask select, bit n selects acceptance mask n
  function [3:0] mask_decode;
    input [1:0] code;
    begin
      case (code)
        `CAFC_MASK_CODE0: mask_decode = 4'h1; // [R04]
        `CAFC_MASK_CODE1: mask_decode = 4'h2; // [R08]
        `CAFC_MASK_CODE2: mask_decode = 4'h4; // [R03]
        `CAFC_MASK_CODE3: mask_decode = 4'h8; // [R03]
        default:          mask_decode = 4'h1;
      endcase
    end
  endfunction

  // Lane of filter n inside the control word
  function integer slot_lsb;
    input integer n;
    begin
      slot_lsb = (n == 0) ? `CAFC_FLT24_LSB : `CAFC_FLT25_LSB;
    end
  endfunction

  // Address decode
  wire hit_ctrl_w   = (reg_addr_in == `CAFC_ADDR_CTRL);
  wire hit_status_w = (reg_addr_in == `CAFC_ADDR_STATUS);
  wire hit_hits_w   = (reg_addr_in == `CAFC_ADDR_HITS);
  wire wr_ctrl_w    = reg_wr_in & hit_ctrl_w;
  wire wr_status_w  = reg_wr_in & hit_status_w;
  wire wr_hits_w    = reg_wr_in & hit_hits_w;

  // Per-filter state
  wire [NFLT-1:0]       on_w;
  wire [NFLT*2-1:0]     mask_w;
  wire [NFLT*5-1:0]     dest_w;
  wire [NFLT*4-1:0]     onehot_w;
  wire [NFLT-1:0]       refused_w;
  wire [NFLT-1:0]       accept_w;
  wire [NFLT*CNT_W-1:0] hits_w;
  wire [31:0]           ctrl_word_w;

  wire [NFLT-1:0]       refused_flags_w;

  genvar g;
  generate
    for (g = 0; g < NFLT; g = g + 1) begin : g_flt
      localparam LSB = slot_lsb(g);
      reg [CNT_W-1:0] hits_q;
      // One flag per lane keeps a single process on each register
      reg             refused_q;

      cafc_filter_slot u_slot (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .wr_in       (wr_ctrl_w),
        .wdata_in    (reg_wdata_in[LSB+`CAFC_SLOT_W-1:LSB]),
        .on_out      (on_w[g]),
        .mask_out    (mask_w[g*2+1:g*2]),
        .dest_out    (dest_w[g*5+4:g*5]),
        .refused_out (refused_w[g])
      );

      assign onehot_w[g*4+3:g*4] = mask_decode(mask_w[g*2+1:g*2]);
      // A match from a switched-off filter is dropped here
      assign accept_w[g] = match_in[g] & on_w[g]; // [R09]

      // Write of any value clears; a hit in the same cycle still counts
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          hits_q <= {CNT_W{1'b0}};
        end else if (accept_w[g]) begin
          hits_q <= (wr_hits_w ? {CNT_W{1'b0}} : hits_q) + {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (wr_hits_w) begin
          hits_q <= {CNT_W{1'b0}};
        end
      end
      assign hits_w[g*CNT_W+CNT_W-1:g*CNT_W] = hits_q;

      // Sticky refused flag, write one to clear, set wins
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          refused_q <= 1'b0;
        end else if (refused_w[g]) begin
          refused_q <= 1'b1;
        end else if (wr_status_w & reg_wdata_in[`CAFC_ST_REFUSED_LSB+g]) begin
          refused_q <= 1'b0;
        end
      end
      assign refused_flags_w[g] = refused_q;

      assign ctrl_word_w[LSB+`CAFC_ON_BIT]                  = on_w[g];
      assign ctrl_word_w[LSB+`CAFC_MASK_MSB:LSB+`CAFC_MASK_LSB] = mask_w[g*2+1:g*2];
      assign ctrl_word_w[LSB+`CAFC_DEST_MSB:LSB+`CAFC_DEST_LSB] = dest_w[g*5+4:g*5];
    end
  endgenerate

  // Upper half belongs to other filters and reads as zero here
  assign ctrl_word_w[31:16] = 16'h0000;

  // Steering: on a double hit the lower-numbered filter wins, as in the
  // usual CAN filter priority; the other message copy is not duplicated
  reg       route_valid_q;
  reg [4:0] route_fifo_q;
  reg       route_filter_q;
  reg       seen_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      route_valid_q  <= 1'b0;
      route_fifo_q   <= `CAFC_RST_DEST;
      route_filter_q <= 1'b0;
      seen_q         <= 1'b0;
    end else begin
      route_valid_q <= |accept_w; // [R09]
      if (accept_w[0]) begin
        route_fifo_q   <= dest_w[4:0]; // [R06]
        route_filter_q <= 1'b0;
        seen_q         <= 1'b1;
      end else if (accept_w[1]) begin
        route_fifo_q   <= dest_w[9:5]; // [R05]
        route_filter_q <= 1'b1;
        seen_q         <= 1'b1;
      end else if (wr_status_w & reg_wdata_in[`CAFC_ST_SEEN_BIT]) begin
        seen_q <= 1'b0;
      end
    end
  end

  // Status word
  wire [31:0] status_word_w;
  assign status_word_w = {16'h0000,
                          3'h0, route_fifo_q,
                          2'h0, route_filter_q, seen_q,
                          2'h0, refused_flags_w};

  // Read data: valid only in the cycle after the read strobe
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = `CAFC_RST_WORD;
    if (reg_rd_in) begin
      if (hit_ctrl_w) begin
        rdata_d = ctrl_word_w; // [R01] [R02]
      end else if (hit_status_w) begin
        rdata_d = status_word_w;
      end else if (hit_hits_w) begin
        rdata_d = {hits_w[2*CNT_W-1:CNT_W], hits_w[CNT_W-1:0]};
      end
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= `CAFC_RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out            = rdata_q;
  assign filter24_on_out          = on_w[0]; // [R02]
  assign filter25_on_out          = on_w[1]; // [R01]
  assign filter24_mask_pick_out   = mask_w[1:0]; // [R04]
  assign filter25_mask_pick_out   = mask_w[3:2]; // [R03]
  assign filter24_mask_onehot_out = onehot_w[3:0];
  assign filter25_mask_onehot_out = onehot_w[7:4];
  assign filter24_fifo_dest_out   = dest_w[4:0]; // [R06]
  assign filter25_fifo_dest_out   = dest_w[9:5]; // [R05]
  assign route_valid_out          = route_valid_q;
  assign route_fifo_out           = route_fifo_q;
  assign route_filter_out         = route_filter_q;

endmodule // cafc_filter_ctrl

// >>> cafc_filter_ctrl_chk.sv
// Checker of register fields and steering for filters 24 and 25
`timescale 1ns/1ps
`include "cafc_map.vh"

module cafc_filter_ctrl_chk #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire                    clk_in,
  input wire                    rst_in,
  // Register writes
  input wire [`CAFC_ADDR_W-1:0] reg_addr_in,
  input wire [31:0]             reg_wdata_in,
  input wire                    reg_wr_in,
  // Steering
  input wire [1:0]              match_in,
  input wire                    filter24_on_out,
  input wire                    filter25_on_out,
  input wire [1:0]              filter24_mask_pick_out,
  input wire [1:0]              filter25_mask_pick_out,
  input wire [3:0]              filter24_mask_onehot_out,
  input wire [3:0]              filter25_mask_onehot_out,
  input wire [4:0]              filter24_fifo_dest_out,
  input wire [4:0]              filter25_fifo_dest_out,
  input wire                    route_valid_out,
  input wire [4:0]              route_fifo_out,
  input wire                    route_filter_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire ctrl_wr = reg_wr_in && reg_addr_in == `CAFC_ADDR_CTRL;
  wire hit24   = match_in[0] && filter24_on_out;
  wire hit25   = match_in[1] && filter25_on_out;

  AST_ON25: assert property (ctrl_wr |=> filter25_on_out == $past(reg_wdata_in[15]))
    else $error("filter 25 enable not written");
  AST_ON24: assert property (ctrl_wr |=> filter24_on_out == $past(reg_wdata_in[7]))
    else $error("filter 24 enable not written");
  AST_MASK25: assert property (filter25_mask_onehot_out == 4'h1 << filter25_mask_pick_out)
    else $error("filter 25 mask decode wrong");
  AST_MASK24: assert property (filter24_mask_onehot_out == 4'h1 << filter24_mask_pick_out)
    else $error("filter 24 mask decode wrong");
  AST_ROUTE25: assert property (hit25 && !hit24 |=> route_valid_out && route_filter_out &&
    route_fifo_out == $past(filter25_fifo_dest_out)) else $error("filter 25 steering wrong");
  AST_ROUTE24: assert property (hit24 |=> route_valid_out && !route_filter_out &&
    route_fifo_out == $past(filter24_fifo_dest_out)) else $error("filter 24 steering wrong");
  AST_LOCK24: assert property (filter24_on_out |=> $stable({filter24_mask_pick_out, filter24_fifo_dest_out}))
    else $error("filter 24 fields changed while enabled");
  AST_LOCK25: assert property (filter25_on_out |=> $stable({filter25_mask_pick_out, filter25_fifo_dest_out}))
    else $error("filter 25 fields changed while enabled");
  AST_IDLE: assert property (!hit24 && !hit25 |=> !route_valid_out)
    else $error("message routed through a disabled filter");
endmodule // cafc_filter_ctrl_chk

bind cafc_filter_ctrl cafc_filter_ctrl_chk #(.CNT_W(CNT_W)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .match_in(match_in), .filter24_on_out(filter24_on_out),
  .filter25_on_out(filter25_on_out), .filter24_mask_pick_out(filter24_mask_pick_out),
  .filter25_mask_pick_out(filter25_mask_pick_out), .filter24_mask_onehot_out(filter24_mask_onehot_out),
  .filter25_mask_onehot_out(filter25_mask_onehot_out), .filter24_fifo_dest_out(filter24_fifo_dest_out),
  .filter25_fifo_dest_out(filter25_fifo_dest_out), .route_valid_out(route_valid_out),
  .route_fifo_out(route_fifo_out), .route_filter_out(route_filter_out));

// >>> cafc_filter_ctrl_tb_top.sv
// Self-checking testbench of the filter 24 and 25 control block
`timescale 1ns/1ps

module cafc_filter_ctrl_tb_top;
  reg         clk_in, rst_in, reg_wr_in, reg_rd_in;
  reg  [7:0]  reg_addr_in;
  reg  [31:0] reg_wdata_in, v;
  reg  [1:0]  match_in, m;
  reg  [15:0] ctl;
  wire [31:0] reg_rdata_out;
  wire [3:0]  oh24, oh25;
  wire [4:0]  d24, d25, route_fifo_out;
  wire        route_valid_out, route_filter_out, on24, on25;
  wire [1:0]  mp24, mp25;
  integer     seed, err_count, checked, i;

  cafc_filter_ctrl dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .match_in(match_in),
    .filter24_on_out(on24), .filter25_on_out(on25), .filter24_mask_pick_out(mp24), .filter25_mask_pick_out(mp25),
    .filter24_mask_onehot_out(oh24), .filter25_mask_onehot_out(oh25), .filter24_fifo_dest_out(d24),
    .filter25_fifo_dest_out(d25), .route_valid_out(route_valid_out), .route_fifo_out(route_fifo_out),
    .route_filter_out(route_filter_out));

  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end

  // Enabled lane keeps mask and destination, only its enable is taken
  function [7:0] lane(input [7:0] o, input [7:0] n);
    lane = o[7] ? {n[7], o[6:0]} : n;
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      reg_wr_in <= 1; reg_addr_in <= a; reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 0;
      if (a == 8'h00) ctl = {lane(ctl[15:8], d[15:8]), lane(ctl[7:0], d[7:0])};
    end
  endtask

  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk_in);
      reg_rd_in <= 1; reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 0;
      #1 chk(reg_rdata_out, e);
    end
  endtask

  task step(input [1:0] mm);
    reg hv, f;
    begin
      hv = (mm[0] & ctl[7]) | (mm[1] & ctl[15]);
      f = !(mm[0] & ctl[7]);
      @(posedge clk_in);
      match_in <= mm;
      @(posedge clk_in);
      match_in <= 2'h0;
      #1 chk(route_valid_out, hv);
      if (hv) chk({route_filter_out, route_fifo_out}, {f, f ? ctl[12:8] : ctl[4:0]});
    end
  endtask

  task results;
    begin
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    #200000 err_count = err_count + 1;
    results;
  end

  initial begin
    seed = 32'h15279d27; err_count = 0; checked = 0; ctl = 16'h0000;
    rst_in = 1; reg_wr_in = 0; reg_rd_in = 0; reg_addr_in = 0; reg_wdata_in = 0; match_in = 0;
    repeat (16) @(posedge clk_in);
    rst_in <= 0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      m = i[1:0];
      v = $random(seed);
      wr(8'h00, {16'h0000, 1'b0, m, v[12:8], 1'b0, ~m, v[4:0]});
      #1 chk({oh25, oh24}, {4'h1 << m, 4'h1 << ~m});
      chk({d25, d24}, {ctl[12:8], ctl[4:0]});
    end
    wr(8'h00, 32'h0000_A3C1);
    step(2'h3);
    wr(8'h00, 32'h0000_1F1F);
    rd(8'h00, {16'h0000, ctl});
    // Both lanes were locked against other fields, so both refused flags stand
    rd(8'h04, 32'h0000_0113);
    step(2'h3);
    // Matches on switched-off filters must not be counted
    rd(8'h08, 32'h0001_0001);
    wr(8'h04, 32'h0000_0013);
    wr(8'h08, 32'h0000_0000);
    rd(8'h04, 32'h0000_0100);
    rd(8'h08, 32'h0000_0000);
    for (i = 0; i < 60; i = i + 1) begin
      v = $random(seed);
      wr(8'h00, v);
      #1 chk({on25, mp25, d25, on24, mp24, d24}, ctl);
      rd(8'h00, {16'h0000, ctl});
      step(v[17:16]);
    end
    results;
  end
endmodule // cafc_filter_ctrl_tb_top

// >>> cafc_filter_slot.v
// One acceptance filter: enable, mask pick and FIFO destination with write lock
`timescale 1ns/1ps
`include "cafc_map.vh"

module cafc_filter_slot (
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // Write port for this filter's byte
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  // Held fields
  output wire       on_out,
  output wire [1:0] mask_out,
  output wire [4:0] dest_out,
  // Write attempt that tried to change locked fields
  output wire       refused_out
);

  reg       on_q;
  reg [1:0] mask_q;
  reg [4:0] dest_q;

  wire [1:0] new_mask_w = wdata_in[`CAFC_MASK_MSB:`CAFC_MASK_LSB];
  wire [4:0] new_dest_w = wdata_in[`CAFC_DEST_MSB:`CAFC_DEST_LSB];
  // Lock follows the enable as it stands before the write, so one write may
  // load fields and switch the filter on together
  wire       open_w     = ~on_q;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      on_q   <= `CAFC_RST_ON;
      mask_q <= `CAFC_RST_MASK;
      dest_q <= `CAFC_RST_DEST;
    end else if (wr_in) begin
      on_q <= wdata_in[`CAFC_ON_BIT];
      if (open_w) begin // [R07]
        mask_q <= new_mask_w;
        dest_q <= new_dest_w;
      end
    end
  end

  assign on_out      = on_q;
  assign mask_out    = mask_q;
  assign dest_out    = dest_q;
  assign refused_out = wr_in & ~open_w & ((new_mask_w != mask_q) | (new_dest_w != dest_q)); // [R07]

endmodule // cafc_filter_slot

// >>> cafc_map.vh
// Register offsets, field positions and reset values of the filter control block
`ifndef CAFC_MAP_VH
`define CAFC_MAP_VH

// Register byte addresses
`define CAFC_ADDR_W          8
`define CAFC_ADDR_CTRL       8'h00
`define CAFC_ADDR_STATUS     8'h04
`define CAFC_ADDR_HITS       8'h08

// Per-filter byte lanes inside the control word
`define CAFC_FLT24_LSB       0
`define CAFC_FLT25_LSB       8
`define CAFC_SLOT_W          8

// Fields inside one filter byte
`define CAFC_ON_BIT          7
`define CAFC_MASK_MSB        6
`define CAFC_MASK_LSB        5
`define CAFC_DEST_MSB        4
`define CAFC_DEST_LSB        0

// Status word fields
`define CAFC_ST_REFUSED_LSB  0
`define CAFC_ST_SEEN_BIT     4
`define CAFC_ST_LAST_FLT_BIT 5
`define CAFC_ST_LAST_DST_LSB 8

// Hit counter lanes
`define CAFC_HITS24_LSB      0
`define CAFC_HITS25_LSB      16

// Mask select codes
`define CAFC_MASK_CODE0      2'h0
`define CAFC_MASK_CODE1      2'h1
`define CAFC_MASK_CODE2      2'h2
`define CAFC_MASK_CODE3      2'h3

// Reset values
`define CAFC_RST_ON          1'h0
`define CAFC_RST_MASK        2'h0
`define CAFC_RST_DEST        5'h00
`define CAFC_RST_WORD        32'h0000_0000

`endif
